//--- rtl/parc_ctrl.sv
`timescale 1ns/10ps
// Function
// - controller pulses memory precharge, then sample, at end of integration
// - readout of held memory runs during next integration
// - boost select sets internal memory boost low or high level
// - without dual slope, pixel reset follows external reset
// - dual slope reset pulse gives second reset to lower level
// - primary reset wins over dual slope reset
// - row sync starts readout at row start address, resyncs register
// - after row sync, each row clock rising edge selects next line
// - column sync starts line at column start address, resyncs register
// - start addresses arrive serially on one address line
// - serial clock shifts each address bit in
// - load pulse copies serial register to start addresses
// - column precharge shortens row blanking after new line
// - output load enable switches on active output load
// - column end of scan flags last column of full line
// - row end of scan flags last row of full frame
// - no end of scan during windowed readout
// - all control inputs filtered against spikes
// - first line after row sync is row start address
// - column clock rise routes first 16 bus columns
// - column clock fall routes last 16 bus columns
module parc_ctrl #(
  parameter int ROW_W = parc_pkg::ROW_W,
  parameter int COL_W = parc_pkg::COL_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic precharge_in,
  input wire logic sample_in,
  input wire logic memory_boost_level_select,
  input wire logic reset_in,
  input wire logic dual_slope_reset,
  input wire logic row_sync,
  input wire logic row_clk,
  input wire logic col_sync,
  input wire logic col_clk,
  input wire logic addr_serial,
  input wire logic serial_clk,
  input wire logic addr_load,
  input wire logic column_track_hold,
  input wire logic row_deselect,
  input wire logic col_precharge,
  input wire logic out_load_en,
  output logic mem_precharge,
  output logic mem_sample,
  output logic mem_boost_high,
  output logic pix_reset,
  output logic pix_reset_low_level,
  output logic [ROW_W-1:0] row_sel,
  output logic row_sel_valid,
  output logic [COL_W-1:0] col_sel,
  output logic col_half_hi,
  output logic col_track_hold_out,
  output logic col_deselect_out,
  output logic col_precharge_out,
  output logic active_load_on,
  output logic col_end_of_scan,
  output logic row_end_of_scan
);
  localparam int NIN = 16;
  localparam int SER_W = ROW_W + COL_W;

  // two-flop sync then a majority-free stability filter per input
  logic [NIN-1:0] raw, s1_reg, s2_reg, f_reg, f_next;
  logic [NIN-1:0] q1_reg;
  logic [NIN-1:0] q1_next;
  assign raw = {precharge_in, sample_in, memory_boost_level_select,
                reset_in, dual_slope_reset, row_sync, row_clk, col_sync,
                col_clk, addr_serial, serial_clk, addr_load,
                column_track_hold, row_deselect, col_precharge, out_load_en};

  // filtered bit takes a new level only after it holds FILT_N samples
  always_comb begin
    f_next = f_reg;
    q1_next = s2_reg;
    for (int i = 0; i < NIN; i++) begin
      if (s2_reg[i] == q1_reg[i]) begin
        f_next[i] = s2_reg[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      q1_reg <= '0;
      f_reg <= '0;
    end else if (ce) begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      q1_reg <= s2_reg;
      f_reg <= f_next;
    end
  end

  logic f_pre, f_smp, f_boost, f_rst, f_ds, f_rsync, f_rclk, f_csync;
  logic f_cclk, f_addr, f_sclk, f_load, f_th, f_desel, f_pcol, f_oload;
  assign {f_pre, f_smp, f_boost, f_rst, f_ds, f_rsync, f_rclk, f_csync,
          f_cclk, f_addr, f_sclk, f_load, f_th, f_desel, f_pcol,
          f_oload} = f_reg;

  // edge history of the filtered clocks
  logic rclk_d_reg, cclk_d_reg, sclk_d_reg, load_d_reg;
  logic rclk_rise, cclk_rise, cclk_fall, sclk_rise, load_rise;
  assign rclk_rise = f_rclk & ~rclk_d_reg;
  assign cclk_rise = f_cclk & ~cclk_d_reg;
  assign cclk_fall = ~f_cclk & cclk_d_reg;
  assign sclk_rise = f_sclk & ~sclk_d_reg;
  assign load_rise = f_load & ~load_d_reg;

  // serial address and start registers
  logic [SER_W-1:0] shift_reg, shift_next;
  logic [ROW_W-1:0] row_start_reg, row_start_next;
  logic [COL_W-1:0] col_start_reg, col_start_next;

  always_comb begin
    shift_next = shift_reg;
    row_start_next = row_start_reg;
    col_start_next = col_start_reg;
    if (sclk_rise) begin
      shift_next = {shift_reg[SER_W-2:0], f_addr};
    end
    if (load_rise) begin
      row_start_next = shift_reg[SER_W-1:COL_W];
      col_start_next = shift_reg[COL_W-1:0];
    end
  end

  // row and column scan counters
  logic [ROW_W-1:0] row_reg, row_next;
  logic [COL_W-1:0] col_reg, col_next;
  logic row_act_reg, row_act_next, col_half_reg, col_half_next;
  logic row_full_reg, row_full_next, col_full_reg, col_full_next;
  logic row_eos_reg, row_eos_next, col_eos_reg, col_eos_next;

  function automatic logic is_full(input logic [SER_W-1:0] v,
                                   input logic [SER_W-1:0] origin);
    is_full = (v == origin);
  endfunction

  always_comb begin
    row_next = row_reg;
    row_act_next = row_act_reg;
    row_full_next = row_full_reg;
    col_next = col_reg;
    col_half_next = col_half_reg;
    col_full_next = col_full_reg;
    if (rclk_rise) begin
      if (f_rsync) begin
        row_next = row_start_reg;
        row_act_next = 1'b1;
        row_full_next = is_full(SER_W'(row_start_reg),
                                SER_W'(parc_pkg::ROW_ORIGIN));
      end else if (row_act_reg) begin
        row_next = ROW_W'(row_reg + 1'b1);
      end
    end
    if (cclk_rise) begin
      col_half_next = parc_pkg::HALF_LO[0];
      if (f_csync) begin
        col_next = col_start_reg;
        col_full_next = is_full(SER_W'(col_start_reg),
                                SER_W'(parc_pkg::COL_ORIGIN));
      end else begin
        col_next = COL_W'(col_reg + 1'b1);
      end
    end else if (cclk_fall) begin
      col_half_next = parc_pkg::HALF_HI[0];
    end
    // end of scan only when scan began at origin; windows stay silent
    row_eos_next = row_act_reg & row_full_reg &
                   (row_reg == parc_pkg::ROW_LAST);
    col_eos_next = col_full_reg &
                   (col_reg == parc_pkg::COL_LAST);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rclk_d_reg <= 1'b0;
      cclk_d_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
      load_d_reg <= 1'b0;
      shift_reg <= '0;
      row_start_reg <= '0;
      col_start_reg <= '0;
      row_reg <= '0;
      row_act_reg <= 1'b0;
      row_full_reg <= 1'b0;
      col_reg <= '0;
      col_half_reg <= 1'b0;
      col_full_reg <= 1'b0;
      row_eos_reg <= 1'b0;
      col_eos_reg <= 1'b0;
    end else if (ce) begin
      rclk_d_reg <= f_rclk;
      cclk_d_reg <= f_cclk;
      sclk_d_reg <= f_sclk;
      load_d_reg <= f_load;
      shift_reg <= shift_next;
      row_start_reg <= row_start_next;
      col_start_reg <= col_start_next;
      row_reg <= row_next;
      row_act_reg <= row_act_next;
      row_full_reg <= row_full_next;
      col_reg <= col_next;
      col_half_reg <= col_half_next;
      col_full_reg <= col_full_next;
      row_eos_reg <= row_eos_next;
      col_eos_reg <= col_eos_next;
    end
  end

  // pixel reset drive: primary level dominates the dual slope level
  parc_pkg::parc_rst_t rst_state;
  logic pix_reset_next, pix_low_next;
  always_comb begin
    if (f_rst) begin
      rst_state = parc_pkg::PARC_RST_MAIN;
    end else if (f_ds) begin
      rst_state = parc_pkg::PARC_RST_DUAL;
    end else begin
      rst_state = parc_pkg::PARC_RST_IDLE;
    end
    pix_reset_next = 1'b0;
    pix_low_next = 1'b0;
    case (rst_state)
      parc_pkg::PARC_RST_MAIN: begin
        pix_reset_next = 1'b1;
      end
      parc_pkg::PARC_RST_DUAL: begin
        pix_reset_next = 1'b1;
        pix_low_next = 1'b1;
      end
      default: begin
        pix_reset_next = 1'b0;
      end
    endcase
  end

  // pixel pulse outputs registered; memory held, so scan is independent
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_precharge <= 1'b0;
      mem_sample <= 1'b0;
      mem_boost_high <= 1'b0;
      pix_reset <= 1'b0;
      pix_reset_low_level <= 1'b0;
      col_track_hold_out <= 1'b0;
      col_deselect_out <= 1'b0;
      col_precharge_out <= 1'b0;
      active_load_on <= 1'b0;
    end else if (ce) begin
      mem_precharge <= f_pre;
      mem_sample <= f_smp;
      mem_boost_high <= f_boost;
      pix_reset <= pix_reset_next;
      pix_reset_low_level <= pix_low_next;
      col_track_hold_out <= f_th;
      col_deselect_out <= f_desel;
      col_precharge_out <= f_pcol;
      active_load_on <= f_oload;
    end
  end

  assign row_sel = row_reg;
  assign row_sel_valid = row_act_reg;
  assign col_sel = col_reg;
  assign col_half_hi = col_half_reg;
  assign row_end_of_scan = row_eos_reg;
  assign col_end_of_scan = col_eos_reg;

  property p_dual_low;
    @(posedge mclk) disable iff (rst)
    ce && $past(ce) && $past(f_ds && !f_rst) |-> pix_reset_low_level;
  endproperty
  a_dual_low: assert property (p_dual_low)
    else $error("dual slope level missing");
  property p_main_wins;
    @(posedge mclk) disable iff (rst)
    ce && $past(ce) && $past(f_rst) |-> pix_reset && !pix_reset_low_level;
  endproperty
  a_main_wins: assert property (p_main_wins)
    else $error("primary reset not dominant");
  property p_row_start;
    @(posedge mclk) disable iff (rst)
    ce && rclk_rise && f_rsync |=> row_reg == $past(row_start_reg);
  endproperty
  a_row_start: assert property (p_row_start)
    else $error("row did not start at start address");
  property p_row_adv;
    @(posedge mclk) disable iff (rst)
    ce && rclk_rise && !f_rsync && row_act_reg
      |=> row_reg == ROW_W'($past(row_reg) + 1'b1);
  endproperty
  a_row_adv: assert property (p_row_adv)
    else $error("row did not advance");
  property p_col_start;
    @(posedge mclk) disable iff (rst)
    ce && cclk_rise && f_csync |=> col_reg == $past(col_start_reg);
  endproperty
  a_col_start: assert property (p_col_start)
    else $error("column did not start at start address");
  property p_load;
    @(posedge mclk) disable iff (rst)
    ce && load_rise |=> row_start_reg == $past(shift_reg[SER_W-1:COL_W]);
  endproperty
  a_load: assert property (p_load)
    else $error("address load failed");
  property p_win_eos;
    @(posedge mclk) disable iff (rst)
    !row_full_reg && !col_full_reg |=> !row_end_of_scan && !col_end_of_scan;
  endproperty
  a_win_eos: assert property (p_win_eos)
    else $error("end of scan during window");
  property p_half;
    @(posedge mclk) disable iff (rst)
    ce && cclk_fall |=> col_half_hi;
  endproperty
  a_half: assert property (p_half)
    else $error("upper half not routed");
  c_row: cover property (@(posedge mclk) row_end_of_scan);
  c_col: cover property (@(posedge mclk) col_end_of_scan);
  c_dual: cover property (@(posedge mclk) pix_reset_low_level);
endmodule

//--- include/parc_pkg.sv
package parc_pkg;
  localparam int ROW_W = 10;
  localparam int COL_W = 6;
  localparam int SER_W = ROW_W + COL_W;
  localparam logic [ROW_W-1:0] ROW_LAST = 10'h3FF;
  localparam logic [COL_W-1:0] COL_LAST = 6'h27;
  localparam logic [ROW_W-1:0] ROW_ORIGIN = 10'h000;
  localparam logic [COL_W-1:0] COL_ORIGIN = 6'h00;
  localparam int FILT_N = 2;
  localparam logic [1:0] HALF_LO = 2'h0;
  localparam logic [1:0] HALF_HI = 2'h1;
  typedef enum logic [1:0] {
    PARC_RST_IDLE = 2'b00,
    PARC_RST_MAIN = 2'b01,
    PARC_RST_DUAL = 2'b10
  } parc_rst_t;
endpackage

//--- dv/parc_link_model.sv
`timescale 1ns/10ps
module parc_link_model (
  output logic addr_serial,
  output logic serial_clk,
  output logic addr_load,
  output logic row_sync,
  output logic row_clk,
  output logic col_sync,
  output logic col_clk
);
  initial begin
    {addr_serial, serial_clk, addr_load} = 3'h0;
    {row_sync, row_clk, col_sync, col_clk} = 4'h0;
  end
  // msb first, row bits then column bits, serial clock idle low
  task automatic load_origin(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      addr_serial = v[i];
      #100 serial_clk = 1'b1;
      #200 serial_clk = 1'b0;
      #100;
    end
    // no pull on the line, so it must not keep showing the last bit
    addr_serial = ~addr_serial;
    addr_load = 1'b1;
    #400 addr_load = 1'b0;
    #400;
  endtask
  // sync spans exactly one rising edge of the chosen clock
  task automatic edge_step(input bit col, input bit lvl, input bit sync);
    if (col) begin
      if (lvl) col_sync = sync;
      col_clk = lvl;
    end else begin
      if (lvl) row_sync = sync;
      row_clk = lvl;
    end
    #200;
    if (col) col_sync = 1'b0;
    else row_sync = 1'b0;
  endtask
endmodule

//--- dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic mclk, rst, precharge_in, sample_in, memory_boost_level_select;
  logic reset_in, dual_slope_reset, column_track_hold, row_deselect;
  logic col_precharge, out_load_en, addr_serial, serial_clk, addr_load;
  logic row_sync, row_clk, col_sync, col_clk, mem_precharge, mem_sample;
  logic mem_boost_high, pix_reset, pix_reset_low_level, row_sel_valid;
  logic col_half_hi, col_track_hold_out, col_deselect_out;
  logic col_precharge_out, active_load_on, col_end_of_scan, row_end_of_scan;
  logic [parc_pkg::ROW_W-1:0] row_sel, r;
  logic [parc_pkg::COL_W-1:0] col_sel, c;
  logic [31:0] seed;
  int fail_count, checked, cyc;
  bit full;

  parc_link_model parc_link_model_inst (.addr_serial, .serial_clk,
    .addr_load, .row_sync, .row_clk, .col_sync, .col_clk);

  parc_ctrl parc_ctrl_inst (.mclk, .rst, .ce(1'b1), .precharge_in,
    .sample_in, .memory_boost_level_select, .reset_in, .dual_slope_reset,
    .row_sync, .row_clk, .col_sync, .col_clk, .addr_serial, .serial_clk,
    .addr_load, .column_track_hold, .row_deselect, .col_precharge,
    .out_load_en, .mem_precharge, .mem_sample, .mem_boost_high, .pix_reset,
    .pix_reset_low_level, .row_sel, .row_sel_valid, .col_sel, .col_half_hi,
    .col_track_hold_out, .col_deselect_out, .col_precharge_out,
    .active_load_on, .col_end_of_scan, .row_end_of_scan);

  always #25 mclk = ~mclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [4:0] exp_levels(input logic [4:0] s);
    return {s[0], s[1], s[2] & ~s[1], s[3], s[4]};
  endfunction

  task automatic chk(input string n, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic nclk(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic tick(input bit col, input bit sync);
    parc_link_model_inst.edge_step(col, 1'b1, sync);
    parc_link_model_inst.edge_step(col, 1'b0, 1'b0);
  endtask

  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc > 80000) begin
      fail_count++;
      end_of_test();
    end
  end

  initial begin
    {mclk, precharge_in, sample_in, memory_boost_level_select} = 4'h0;
    {reset_in, dual_slope_reset, column_track_hold, row_deselect} = 4'h0;
    {col_precharge, out_load_en} = 2'h0;
    rst = 1'b1;
    seed = 32'h0000_9a01;
    nclk(8);
    rst = 1'b0;
    chk("reset outputs", {mem_precharge, pix_reset, row_sel, col_sel,
        row_end_of_scan, col_end_of_scan, active_load_on}, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      // deselect only when track-hold is off: one column mode at a time
      {out_load_en, col_precharge} = seed[4:3];
      column_track_hold = seed[1];
      memory_boost_level_select = seed[0];
      row_deselect = seed[2] & ~seed[1];
      nclk(8);
      chk("levels", {mem_boost_high, col_track_hold_out,
          col_deselect_out, col_precharge_out, active_load_on},
          exp_levels(seed[4:0]));
    end
    precharge_in = 1'b1;
    nclk(1);
    precharge_in = 1'b0;
    repeat (8) begin
      nclk(1);
      chk("spike", mem_precharge, 32'h0000_0000);
    end
    precharge_in = 1'b1;
    nclk(8);
    chk("precharge", {mem_precharge, mem_sample}, 32'h0000_0002);
    precharge_in = 1'b0;
    sample_in = 1'b1;
    nclk(8);
    chk("sample", {mem_precharge, mem_sample}, 32'h0000_0001);
    sample_in = 1'b0;
    for (int m = 1; m < 4; m++) begin
      {reset_in, dual_slope_reset} = m[1:0];
      nclk(8);
      chk("pix reset", {pix_reset, pix_reset_low_level},
          {1'b1, !m[1]});
      {reset_in, dual_slope_reset} = 2'h0;
      nclk(8);
      chk("pix idle", {pix_reset, pix_reset_low_level}, 32'h0000_0000);
    end
    for (int w = 0; w < 3; w++) begin
      seed = lfsr(seed);
      full = (w == 0);
      // odd and below the last row, so the window never wraps
      r = full ? 10'h000 : {1'b0, seed[9:2], 1'b1};
      c = full ? 6'h00 : 6'(1 + seed[15:10] % 39);
      parc_link_model_inst.load_origin({r, c});
      parc_link_model_inst.edge_step(1'b0, 1'b1, 1'b1);
      nclk(6);
      chk("row first", {row_sel_valid, row_sel}, {1'b1, r});
      parc_link_model_inst.edge_step(1'b0, 1'b0, 1'b0);
      tick(1'b0, 1'b0);
      nclk(6);
      chk("row next", row_sel, 10'(r + 10'h001));
      parc_link_model_inst.edge_step(1'b1, 1'b1, 1'b1);
      nclk(6);
      chk("col first", {col_sel, col_half_hi}, {c, 1'b0});
      parc_link_model_inst.edge_step(1'b1, 1'b0, 1'b0);
      nclk(6);
      chk("col half", col_half_hi, 32'h0000_0001);
      repeat (int'(parc_pkg::COL_LAST) - int'(c)) tick(1'b1, 1'b0);
      nclk(6);
      chk("col eos", {col_sel, col_end_of_scan},
          {parc_pkg::COL_LAST, full});
      // pixel reset held while rows keep scanning
      reset_in = 1'b1;
      repeat (int'(parc_pkg::ROW_LAST) - int'(r) - 1) tick(1'b0, 1'b0);
      nclk(6);
      chk("row eos", {row_sel, row_end_of_scan, pix_reset},
          {parc_pkg::ROW_LAST, full, 1'b1});
      reset_in = 1'b0;
      nclk(8);
    end
    end_of_test();
  end
endmodule
